// >>> rtl/otc_osc_ctrl.sv
// Operation
// - Trim resets to 100000000B, nominal 12MHz
// - Larger trim value means lower frequency
// - Trim bits split across low/high registers
// - Sub clock comes from slow RC oscillator
// - Normal mode divides fast clock 1..64
// - Switching to sub clock stops fast oscillator
// - Normal mode: CPU runs, both clocks run
// - Slow mode: sub clock, fast clock stopped
// - Halt, no watchdog/detector: deep sleep
// - Detector enabled blocks deep sleep entry
// - Halt with watchdog/detector: light sleep
// - Idle without keep: oscillator stops, sub runs
// - Idle with keep: sub runs, and oscillator runs only when fast clock is selected
// - Keep idle: fast clock follows source
// - Detector enabled forces sub clock on
// - Divider codes select sub or fast/64../2
// - High select picks undivided fast clock
// - Fast stable flag rises after 16 cycles
// - Slow stable flag rises after 2 sub clock ticks
//
// The placing of the registers and the Avalon-MM register port were left to the implementer.
`timescale 1ns/1ps
module otc_osc_ctrl (
  input  wire logic                         clk,
  input  wire logic                         rst_n,
  input  wire logic [otc_pkg::ADDR_W-1:0]   avs_address,
  input  wire logic                         avs_read,
  input  wire logic                         avs_write,
  input  wire logic [31:0]                  avs_writedata,
  input  wire logic [3:0]                   avs_byteenable,
  output logic      [31:0]                  avs_readdata,
  output logic                              avs_waitrequest,
  input  wire logic                         halt,
  input  wire logic                         wake,
  input  wire logic                         watchdog_en,
  input  wire logic                         sub_osc_tick,
  output logic      [otc_pkg::TRIM_W-1:0]   fast_osc_trim,
  output logic                              fast_osc_en,
  output logic                              sub_osc_en,
  output logic                              wdt_lvd_clk_en,
  output logic                              lowvolt_detector_on,
  output logic                              watchdog_stop,
  output logic                              cpu_run,
  output logic                              core_clk_en,
  output logic      [2:0]                   op_mode
);
  import otc_pkg::*;

  typedef struct packed {
    logic [7:0]   trim_low;
    logic         trim_high;
    logic [2:0]   div_sel;
    logic         idle_sel;
    logic         hl_sel;
    logic         keep;
    logic         lvd_en;
    otc_mode_type mode;
    logic [4:0]   fast_cnt;
    logic         fast_stable;
    logic [1:0]   slow_cnt;
    logic         slow_stable;
    logic         waitreq;
    logic [31:0]  rdata;
    logic         fast_en;
    logic         sub_en;
    logic         wl_clk_en;
    logic         wdt_stop;
    logic         cpu_run;
    logic         core_tick;
  } otc_top_type;

  otc_top_type r;
  otc_top_type next_r;

  logic gen_run;
  logic gen_tick;
  logic gen_on_sub;

  ////////////////////////////////////////////////////////////////////////////////
  // Core clock enable generator

  assign gen_run = (r.mode == MODE_NORMAL) || (r.mode == MODE_SLOW)
                   || (r.mode == MODE_IDLE_KEEP);

  otc_clk_gen u_clk_gen (
    .clk         (clk),
    .rst_n       (rst_n),
    .run_en      (gen_run),
    .hl_sel      (r.hl_sel),
    .div_sel     (r.div_sel),
    .fast_ok     (r.fast_stable),
    .sub_ok      (r.slow_stable),
    .sub_tick    (sub_osc_tick),
    .core_clk_en (gen_tick),
    .on_sub      (gen_on_sub)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // Next-state logic

  // Target of a stop-cpu instruction; the watchdog enable is only looked at here
  function automatic otc_mode_type halt_target(
    input logic idle_sel,
    input logic keep,
    input logic wdog_en,
    input logic lvd_en
  );
    otc_mode_type m;
    if (idle_sel) begin
      m = keep ? MODE_IDLE_KEEP : MODE_IDLE_SUB;
    end else if (wdog_en || lvd_en) begin
      m = MODE_SLEEP_LITE;
    end else begin
      m = MODE_SLEEP_DEEP;
    end
    return m;
  endfunction

  // Running mode code for a given core clock source
  function automatic otc_mode_type run_mode(input logic on_sub);
    return on_sub ? MODE_SLOW : MODE_NORMAL;
  endfunction

  // Register read view; unused bits read as zero
  function automatic logic [31:0] read_word(
    input logic [ADDR_W-1:0] addr,
    input otc_top_type       s
  );
    logic [31:0] w;
    w = 32'h0000_0000;
    unique case (addr)
      OFF_TRIM_LOW: begin
        w[7:0] = s.trim_low;
      end
      OFF_TRIM_HIGH: begin
        w[0] = s.trim_high;
      end
      OFF_CLK_MODE: begin
        w[CM_DIV_MSB:CM_DIV_LSB] = s.div_sel;
        w[CM_SLOW_OK] = s.slow_stable;
        w[CM_FAST_OK] = s.fast_stable;
        w[CM_IDLE_SEL] = s.idle_sel;
        w[CM_HL_SEL] = s.hl_sel;
      end
      OFF_IDLE_CTRL: begin
        w[IC_KEEP] = s.keep;
        w[IC_LVD_EN] = s.lvd_en;
      end
      OFF_STATUS: begin
        w[ST_MODE_MSB:0] = s.mode;
      end
      default: begin
        w = 32'h0000_0000;
      end
    endcase
    return w;
  endfunction

  // Register write view; unmapped or read-only offsets leave the state alone
  function automatic otc_top_type write_reg(
    input otc_top_type       s,
    input logic [ADDR_W-1:0] addr,
    input logic [7:0]        data
  );
    otc_top_type t;
    t = s;
    unique case (addr)
      OFF_TRIM_LOW: begin
        t.trim_low = data;
      end
      OFF_TRIM_HIGH: begin
        t.trim_high = data[0];
      end
      OFF_CLK_MODE: begin
        t.div_sel = data[CM_DIV_MSB:CM_DIV_LSB];
        t.idle_sel = data[CM_IDLE_SEL];
        t.hl_sel = data[CM_HL_SEL];
      end
      OFF_IDLE_CTRL: begin
        t.keep = data[IC_KEEP];
        t.lvd_en = data[IC_LVD_EN];
      end
      default: begin
        t = s;
      end
    endcase
    return t;
  endfunction

  logic sel_sub;
  logic running;
  logic req;
  logic wr_lane0;
  logic [7:0] wbyte;

  always_comb begin
    next_r = r;
    sel_sub = !r.hl_sel && (r.div_sel < DIV_CODE_64);
    running = (r.mode == MODE_NORMAL) || (r.mode == MODE_SLOW);
    req = (avs_read || avs_write) && r.waitreq;
    wr_lane0 = avs_write && !r.waitreq && avs_byteenable[0];
    wbyte = avs_writedata[7:0];

    // Bus slave: one wait cycle, then a single-cycle answer
    next_r.waitreq = !req;
    if (req && avs_read) begin
      next_r.rdata = read_word(avs_address, r);
    end

    // A new trim value takes effect at once; settling is left to software
    if (wr_lane0) begin
      next_r = write_reg(next_r, avs_address, wbyte);
    end

    // Operating mode sequencing
    if (running && halt) begin
      next_r.mode = halt_target(r.idle_sel, r.keep, watchdog_en, r.lvd_en);
    end else if (!running && wake) begin
      next_r.mode = run_mode(sel_sub);
    end else if (running) begin
      next_r.mode = run_mode(gen_on_sub);
    end

    // In normal and slow mode the fast oscillator is kept until the generator has left it
    unique case (next_r.mode)
      MODE_NORMAL, MODE_SLOW: begin
        next_r.fast_en = !sel_sub || !gen_on_sub;
      end
      MODE_IDLE_KEEP: begin
        next_r.fast_en = !sel_sub;
      end
      default: begin
        next_r.fast_en = 1'b0;
      end
    endcase
    next_r.core_tick = gen_tick;

    // Sub clock only stops in deep sleep, and never with the detector on
    next_r.sub_en = (next_r.mode != MODE_SLEEP_DEEP) || r.lvd_en;
    next_r.wl_clk_en = next_r.sub_en && (next_r.mode != MODE_SLEEP_DEEP);
    next_r.wdt_stop = (next_r.mode == MODE_SLEEP_DEEP);
    next_r.cpu_run = (next_r.mode == MODE_NORMAL) || (next_r.mode == MODE_SLOW);

    // Settle counters restart whenever an oscillator is switched off
    if (!r.fast_en) begin
      next_r.fast_cnt = 5'h00;
      next_r.fast_stable = 1'b0;
    end else if (!r.fast_stable) begin
      next_r.fast_cnt = 5'(r.fast_cnt + 5'h01);
      next_r.fast_stable = (5'(r.fast_cnt + 5'h01) == FAST_STABLE_CYCLES);
    end
    if (!r.sub_en) begin
      next_r.slow_cnt = 2'h0;
      next_r.slow_stable = 1'b0;
    end else if (!r.slow_stable && sub_osc_tick) begin
      next_r.slow_cnt = 2'(r.slow_cnt + 2'h1);
      next_r.slow_stable = (2'(r.slow_cnt + 2'h1) == SLOW_STABLE_TICKS);
    end

    if (!rst_n) begin
      next_r.trim_low = TRIM_LOW_RST;
      next_r.trim_high = TRIM_HIGH_RST;
      next_r.div_sel = DIV_SEL_RST;
      next_r.idle_sel = IDLE_SEL_RST;
      next_r.hl_sel = HL_SEL_RST;
      next_r.keep = 1'b0;
      next_r.lvd_en = 1'b0;
      next_r.mode = MODE_NORMAL;
      next_r.fast_cnt = 5'h00;
      next_r.fast_stable = 1'b0;
      next_r.slow_cnt = 2'h0;
      next_r.slow_stable = 1'b0;
      next_r.waitreq = 1'b1;
      next_r.rdata = 32'h0000_0000;
      next_r.fast_en = 1'b1;
      next_r.sub_en = 1'b1;
      next_r.wl_clk_en = 1'b1;
      next_r.wdt_stop = 1'b0;
      next_r.cpu_run = 1'b1;
      next_r.core_tick = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign avs_readdata = r.rdata;
  assign avs_waitrequest = r.waitreq;
  assign fast_osc_trim = {r.trim_high, r.trim_low};
  assign fast_osc_en = r.fast_en;
  assign sub_osc_en = r.sub_en;
  assign wdt_lvd_clk_en = r.wl_clk_en;
  assign lowvolt_detector_on = r.lvd_en;
  assign watchdog_stop = r.wdt_stop;
  assign cpu_run = r.cpu_run;
  assign core_clk_en = r.core_tick;
  assign op_mode = r.mode;

endmodule

// >>> rtl/otc_pkg.sv
package otc_pkg;

  // Avalon-MM byte addresses, one aligned word per register
  localparam int unsigned ADDR_W = 5;
  localparam logic [ADDR_W-1:0] OFF_TRIM_LOW  = 5'h00;
  localparam logic [ADDR_W-1:0] OFF_TRIM_HIGH = 5'h04;
  localparam logic [ADDR_W-1:0] OFF_CLK_MODE  = 5'h08;
  localparam logic [ADDR_W-1:0] OFF_IDLE_CTRL = 5'h0C;
  localparam logic [ADDR_W-1:0] OFF_STATUS    = 5'h10;

  // Trim field and reset values
  localparam int unsigned TRIM_W = 9;
  localparam logic [7:0] TRIM_LOW_RST  = 8'h00;
  localparam logic       TRIM_HIGH_RST = 1'b1;

  // Clock mode register layout
  localparam int unsigned CM_DIV_MSB   = 7;
  localparam int unsigned CM_DIV_LSB   = 5;
  localparam int unsigned CM_SLOW_OK   = 3;
  localparam int unsigned CM_FAST_OK   = 2;
  localparam int unsigned CM_IDLE_SEL  = 1;
  localparam int unsigned CM_HL_SEL    = 0;
  localparam logic [2:0] DIV_SEL_RST   = 3'h0;
  localparam logic       IDLE_SEL_RST  = 1'b1;
  localparam logic       HL_SEL_RST    = 1'b1;

  // Idle control register layout
  localparam int unsigned IC_KEEP   = 7;
  localparam int unsigned IC_LVD_EN = 0;

  // Status register layout: mode code in bits 2..0
  localparam int unsigned ST_MODE_MSB = 2;

  // Oscillator settle counts
  localparam logic [4:0] FAST_STABLE_CYCLES = 5'h10;
  localparam logic [1:0] SLOW_STABLE_TICKS  = 2'h2;

  // Divider: code 010 gives /64 ... code 111 gives /2
  localparam logic [2:0] DIV_CODE_64 = 3'h2;
  localparam logic [6:0] DIV_MAX     = 7'h40;

  typedef enum logic [2:0] {
    MODE_NORMAL     = 3'h0,
    MODE_SLOW       = 3'h1,
    MODE_IDLE_SUB   = 3'h3,
    MODE_IDLE_KEEP  = 3'h2,
    MODE_SLEEP_LITE = 3'h6,
    MODE_SLEEP_DEEP = 3'h7
  } otc_mode_type;

endpackage

// >>> rtl/otc_clk_gen.sv
`timescale 1ns/1ps
module otc_clk_gen (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       run_en,
  input  wire logic       hl_sel,
  input  wire logic [2:0] div_sel,
  input  wire logic       fast_ok,
  input  wire logic       sub_ok,
  input  wire logic       sub_tick,
  output logic            core_clk_en,
  output logic            on_sub
);
  import otc_pkg::*;

  typedef struct packed {
    logic [5:0] cnt;
    logic [5:0] limit;
    logic       src_sub;
    logic       tick;
  } otc_gen_type;

  otc_gen_type r;
  otc_gen_type next_r;

  logic       want_sub;
  logic [5:0] want_limit;
  logic       boundary;
  logic [6:0] ratio;

  always_comb begin
    next_r = r;
    want_sub = !hl_sel && (div_sel < DIV_CODE_64);
    ratio = DIV_MAX >> (div_sel - DIV_CODE_64);
    want_limit = hl_sel ? 6'h00 : 6'(ratio - 7'h01);
    boundary = r.src_sub ? sub_tick : (r.cnt == r.limit);
    next_r.tick = 1'b0;
    if (run_en) begin
      next_r.tick = boundary;
      next_r.cnt = boundary ? 6'h00 : 6'(r.cnt + 6'h01);
      // Source or ratio changes only on a period boundary and only onto a settled source
      if (boundary && ((want_sub && sub_ok) || (!want_sub && fast_ok))) begin
        next_r.src_sub = want_sub;
        next_r.limit = want_limit;
      end
    end
    if (!rst_n) begin
      next_r.cnt = 6'h00;
      next_r.limit = 6'h00;
      next_r.src_sub = 1'b0;
      next_r.tick = 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    r <= next_r;
  end

  assign core_clk_en = r.tick;
  assign on_sub = r.src_sub;

endmodule

// >>> testbench/otc_osc_ctrl_props.sv
`timescale 1ns/1ps
module otc_props (
  input wire logic                         clk,
  input wire logic                         rst_n,
  input wire logic                         avs_read,
  input wire logic                         avs_write,
  input wire logic                         avs_waitrequest,
  input wire logic                         halt,
  input wire logic [otc_pkg::TRIM_W-1:0]   fast_osc_trim,
  input wire logic                         fast_osc_en,
  input wire logic                         sub_osc_en,
  input wire logic                         wdt_lvd_clk_en,
  input wire logic                         lowvolt_detector_on,
  input wire logic                         watchdog_stop,
  input wire logic                         cpu_run,
  input wire logic [2:0]                   op_mode
);
  import otc_pkg::*;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);
  ////////////////////////////////////////
  trim_reset_a: assert property ($rose(rst_n) |-> fast_osc_trim == 9'h100)
    else $error("trim reset value wrong");
  bus_wait_a: assert property ($rose(avs_read || avs_write)
    |=> !avs_waitrequest ##1 avs_waitrequest) else $error("bus answer timing wrong");
  run_hold_a: assert property (!op_mode[1] && !halt |=> !op_mode[1])
    else $error("left running mode without halt");
  halt_enter_a: assert property (!op_mode[1] && halt |=> op_mode[1] && !cpu_run)
    else $error("halt not taken");
  normal_clk_a: assert property (op_mode == 3'h0 |-> fast_osc_en && sub_osc_en && cpu_run)
    else $error("normal mode clocks wrong");
  slow_enter_a: assert property (op_mode == 3'h1 && $past(op_mode) == 3'h0
    |-> !fast_osc_en && sub_osc_en && cpu_run) else $error("slow mode clocks wrong");
  deep_sleep_a: assert property (op_mode == 3'h7 |-> !sub_osc_en && watchdog_stop
    && !wdt_lvd_clk_en && !cpu_run) else $error("deep sleep left a clock on");
  light_sleep_a: assert property (op_mode == 3'h6 |-> sub_osc_en && wdt_lvd_clk_en
    && !cpu_run) else $error("light sleep clocks wrong");
  idle_sub_a: assert property (op_mode == 3'h3 |-> !fast_osc_en && sub_osc_en
    && !cpu_run) else $error("sub idle clocks wrong");
  idle_keep_a: assert property (op_mode == 3'h2 |-> sub_osc_en && !cpu_run)
    else $error("keep idle clocks wrong");
  det_block_a: assert property (lowvolt_detector_on && halt && !op_mode[1]
    |=> op_mode != 3'h7) else $error("deep sleep entered with detector on");
  det_sub_a: assert property (lowvolt_detector_on && op_mode[1] |-> sub_osc_en)
    else $error("detector on but sub clock off");
endmodule

bind otc_osc_ctrl otc_props props (.clk, .rst_n, .avs_read, .avs_write, .avs_waitrequest,
  .halt, .fast_osc_trim, .fast_osc_en, .sub_osc_en, .wdt_lvd_clk_en, .lowvolt_detector_on,
  .watchdog_stop, .cpu_run, .op_mode);

// >>> testbench/otc_cpu_model.sv
`timescale 1ns/1ps
module otc_cpu_model #(
  parameter int TICK_DIV = 10
) (
  input  wire logic clk,
  output logic      halt,
  output logic      wake,
  output logic      sub_osc_tick
);
  int cnt = 0;
  initial begin
    halt = 1'b0;
    wake = 1'b0;
    sub_osc_tick = 1'b0;
  end
  // Slow oscillator runs free, so it ignores the core reset
  always @(posedge clk) begin
    cnt <= (cnt == TICK_DIV - 1) ? 0 : cnt + 1;
    sub_osc_tick <= (cnt == TICK_DIV - 1);
  end
  // Stop-cpu or wake as a single-cycle pulse
  task automatic pulse(input logic is_wake);
    @(posedge clk);
    if (is_wake) wake <= 1'b1; else halt <= 1'b1;
    @(posedge clk);
    halt <= 1'b0;
    wake <= 1'b0;
  endtask
endmodule

// >>> testbench/otc_osc_ctrl_test.sv
`timescale 1ns/1ps
module otc_osc_ctrl_test;
  import otc_pkg::*;
  localparam logic [7:0] RST_VAL [6] = '{8'h00, 8'h01, 8'h0F, 8'h00, 8'h00, 8'h00};
  logic                clk, rst_n, avs_read, avs_write, avs_waitrequest, watchdog_en;
  logic [ADDR_W-1:0]   avs_address;
  logic [31:0]         avs_writedata, avs_readdata;
  logic [3:0]          avs_byteenable;
  logic                halt, wake, sub_osc_tick, fast_osc_en, sub_osc_en, wdt_lvd_clk_en;
  logic                lowvolt_detector_on, watchdog_stop, cpu_run, core_clk_en;
  logic [TRIM_W-1:0]   fast_osc_trim;
  logic [2:0]          op_mode;
  logic [7:0]          rd;
  int                  mismatches, n_tests;

  otc_osc_ctrl dut (.clk, .rst_n, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable, .avs_readdata, .avs_waitrequest, .halt, .wake, .watchdog_en,
    .sub_osc_tick, .fast_osc_trim, .fast_osc_en, .sub_osc_en, .wdt_lvd_clk_en,
    .lowvolt_detector_on, .watchdog_stop, .cpu_run, .core_clk_en, .op_mode);
  otc_cpu_model cpu (.clk, .halt, .wake, .sub_osc_tick);

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Request held until the edge that samples waitrequest low
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= {24'h0, d};
    @(posedge clk iff !avs_waitrequest);
    rd = avs_readdata[7:0];
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic period(output int p);
    @(posedge clk iff core_clk_en);
    p = 1;
    @(posedge clk);
    while (!core_clk_en) begin
      p++;
      @(posedge clk);
    end
  endtask
  task automatic wait_mode(input logic [2:0] m);
    for (int i = 0; i < 200 && op_mode !== m; i++) @(posedge clk);
  endtask
  task automatic final_report;
    if (mismatches == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  ////////////////////////////////////////
  task automatic t_reset;
    repeat (40) @(posedge clk);
    chk(fast_osc_trim, 9'h100);
    for (int i = 0; i < 6; i++) begin
      bus(1'b0, 5'(i * 4), 8'h00);
      chk(rd, RST_VAL[i]);
    end
  endtask
  task automatic t_trim;
    bus(1'b1, OFF_TRIM_LOW, 8'hFF);
    bus(1'b1, OFF_TRIM_HIGH, 8'hFF);
    repeat (FAST_STABLE_CYCLES) @(posedge clk);
    chk(fast_osc_trim, 9'h1FF);
    bus(1'b0, OFF_TRIM_HIGH, 8'h00);
    chk(rd, 8'h01);
    avs_byteenable <= 4'hE;
    bus(1'b1, OFF_TRIM_LOW, 8'h00);
    avs_byteenable <= 4'hF;
    bus(1'b0, OFF_TRIM_LOW, 8'h00);
    chk(rd, 8'hFF);
    bus(1'b1, OFF_TRIM_LOW, 8'h00);
    bus(1'b1, OFF_TRIM_HIGH, 8'h00);
    @(posedge clk);
    chk(fast_osc_trim, 9'h000);
    bus(1'b1, OFF_TRIM_HIGH, 8'h01);
  endtask
  task automatic t_div;
    int p, q, e;
    q = 1;
    for (int c = 2; c < 8; c++) begin
      e = 64 >> (c - 2);
      bus(1'b1, OFF_CLK_MODE, {3'(c), 5'h02});
      period(p);
      chk(32'(p == q || p == e), 1);
      period(p);
      chk(p, e);
      q = e;
    end
    bus(1'b1, OFF_CLK_MODE, 8'h03);
    period(p);
    period(p);
    chk(p, 1);
  endtask
  task automatic t_slow;
    bus(1'b1, OFF_CLK_MODE, 8'h02);
    wait_mode(3'h1);
    chk(op_mode, 3'h1);
    chk(fast_osc_en, 1'b0);
    cpu.pulse(1'b0);
    @(posedge clk);
    chk(op_mode, 3'h3);
    cpu.pulse(1'b1);
    @(posedge clk);
    chk(op_mode, 3'h1);
    bus(1'b0, OFF_CLK_MODE, 8'h00);
    chk(rd[2], 1'b0);
    bus(1'b1, OFF_CLK_MODE, 8'h03);
    wait_mode(3'h0);
    chk(op_mode, 3'h0);
    repeat (20) @(posedge clk);
    bus(1'b0, OFF_CLK_MODE, 8'h00);
    chk(rd, 8'h0F);
  endtask
  task automatic t_modes;
    logic       isel, keep, wdog, det;
    logic [2:0] m;
    for (int i = 0; i < 16; i++) begin
      {isel, keep, wdog, det} = 4'(i);
      m = isel ? (keep ? 3'h2 : 3'h3) : ((wdog | det) ? 3'h6 : 3'h7);
      bus(1'b1, OFF_CLK_MODE, {6'h00, isel, 1'b1});
      bus(1'b1, OFF_IDLE_CTRL, {keep, 6'h00, det});
      watchdog_en <= wdog;
      cpu.pulse(1'b0);
      @(posedge clk);
      chk(op_mode, m);
      chk(fast_osc_en, m == 3'h2);
      chk(sub_osc_en, m != 3'h7);
      chk(lowvolt_detector_on, det);
      chk(wdt_lvd_clk_en, m != 3'h7);
      chk(watchdog_stop, m == 3'h7);
      chk(cpu_run, 1'b0);
      cpu.pulse(1'b0);
      @(posedge clk);
      chk(op_mode, m);
      cpu.pulse(1'b1);
      @(posedge clk);
      chk(op_mode, 3'h0);
    end
    cpu.pulse(1'b1);
    @(posedge clk);
    chk(cpu_run, 1'b1);
  endtask
  ////////////////////////////////////////
  initial begin
    rst_n = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = '0;
    avs_writedata = '0;
    avs_byteenable = 4'hF;
    watchdog_en = 1'b0;
    mismatches = 0;
    n_tests = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    t_reset;
    t_trim;
    t_div;
    t_slow;
    t_modes;
    final_report;
  end
  initial begin
    repeat (30000) @(posedge clk);
    mismatches++;
    final_report;
  end
endmodule
